/* logic/isc_pkg.sv */
// Purpose: Shared types and constants of the 16-bit instruction set core
// Assumes: Instructions arrive already decoded as isc_instr_t
// Notes: Operation codes are local to this core, not a binary encoding
// Functional notes
// - Add/subtract word or byte, optional carry.
// - Signed/unsigned 16x16 multiply of two registers.
// - Short divide: low muldiv half by register.
// - Long divide: full muldiv register by register.
// - Complement or negate register, word or byte.
// - Bit copy, bit AND/OR/XOR, bit compare.
// - Masked modify of high or low byte.
// - Compare, then step register by one/two.
// - Count normalise shifts into another register.
// - Shifts, rotates; arithmetic right keeps sign.
// - Byte to word with sign/zero extension.
// - Conditional jumps; segment jump to absolute.
// - Bit-test jumps, then clear or set bit.
// - Conditional absolute/indirect/relative calls, segment call, push-and-call.
// - Trap enters routine chosen by trap number.
// - Context switch: push register, then load it.
// - Distinct intra, inter-segment and interrupt returns.
// - Power-down needs mode-select pin held low.
// - End-init, watchdog, software reset, idle operations.
// - Prefixes open atomic/extended sequences for followers.
// - Multiply-accumulate unit operation set.
// - Null operation only advances program counter.
package isc_pkg;
	localparam int GPR_N = 16;
	localparam int BYTE_MSB = 7;
	localparam int WORD_MSB = 15;
	localparam int TRAP_SHIFT = 2;
	localparam logic [15:0] STEP_SHORT = 16'h0002;
	localparam logic [15:0] STEP_LONG = 16'h0004;
	localparam logic [15:0] STEP_ONE = 16'h0001;
	localparam logic [15:0] STEP_TWO = 16'h0002;
	localparam logic [15:0] RESET_IP = 16'h0000;
	localparam logic [7:0] RESET_SEG = 8'h00;
	localparam logic [15:0] TRAP_BASE = 16'h0000;
	localparam logic [31:0] RND_BIAS = 32'h0000_8000;
	localparam logic [31:0] RND_MASK = 32'hFFFF_0000;
	localparam logic [3:0] CC_ALWAYS = 4'h0;
	localparam logic [3:0] CC_Z = 4'h1;
	localparam logic [3:0] CC_NZ = 4'h2;
	localparam logic [3:0] CC_C = 4'h3;
	localparam logic [3:0] CC_NC = 4'h4;
	localparam logic [3:0] CC_N = 4'h5;
	localparam logic [3:0] CC_NN = 4'h6;
	localparam logic [3:0] CC_V = 4'h7;
	localparam logic [3:0] CC_NV = 4'h8;
	typedef enum logic [6:0] {
		OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_DIV_LONG, OP_CPL, OP_NEG, OP_AND, OP_OR, OP_XOR,
		OP_CMP, OP_MOV, OP_BCLR, OP_BSET, OP_BIT_COPY, OP_BAND, OP_BOR, OP_BXOR, OP_BIT_CMP,
		OP_FIELD, OP_CMP_DEC, OP_CMP_INC, OP_NORM, OP_SHL, OP_SHR, OP_ROL, OP_ROR,
		OP_ARITH_SHR, OP_WIDEN, OP_JMP_ABS, OP_JMP_IND, OP_JMP_REL, OP_JMP_SEG, OP_JMP_BSET,
		OP_JMP_BCLR, OP_CALL_ABS, OP_CALL_IND, OP_CALL_REL, OP_CALL_SEG, OP_PUSH_CALL,
		OP_TRAP, OP_PUSH, OP_POP, OP_CTX, OP_RET, OP_RET_SEG, OP_RET_INT, OP_BREAK,
		OP_SW_RESET, OP_IDLE, OP_PWR_DOWN, OP_WDT_SERVICE, OP_WDT_DIS, OP_WDT_EN,
		OP_END_INIT, OP_ATOMIC, OP_EXT_REG, OP_EXT_PAGE, OP_EXT_SEG, OP_NOP,
		OP_MAC_MUL, OP_MAC_MAC, OP_MAC_ADD, OP_MAC_SUB, OP_MAC_SHR, OP_MAC_ARITH_RIGHT_SHIFT,
		OP_MAC_SHL, OP_MAC_LOAD, OP_MAC_STORE, OP_MAC_CMP, OP_MAC_MAX, OP_MAC_MIN,
		OP_MAC_ABS, OP_MAC_RND, OP_MAC_MOV, OP_MAC_NEG, OP_MAC_NOP
	} isc_op_t;
	typedef struct packed {
		logic c;
		logic z;
		logic n;
		logic v;
	} isc_flags_t;
	typedef struct packed {
		isc_op_t op;
		logic byte_op;
		logic alt;
		logic len4;
		logic [3:0] cc;
		logic [3:0] rd;
		logic [3:0] rs;
		logic [3:0] bit_d;
		logic [3:0] bit_s;
		logic use_imm;
		logic [15:0] imm;
		logic [7:0] seg;
	} isc_instr_t;
	typedef struct packed {
		logic en;
		logic [3:0] idx;
		logic [15:0] data;
	} isc_wb_t;
	typedef enum logic [2:0] {PFX_NONE, PFX_ATOMIC, PFX_REG, PFX_PAGE, PFX_SEG} isc_pfx_kind_t;
	typedef struct packed {
		isc_pfx_kind_t kind;
		logic with_reg;
		logic [2:0] left;
		logic [15:0] value;
	} isc_prefix_t;
endpackage

/* logic/isc_core.sv */
// Purpose: Single-cycle execute core of a 16-bit microcontroller
// Assumes: Decoded instructions from a fetch/decode stage on the same clock
// Notes: Accumulator is 32 bits; stack is a local array
`timescale 1ns/100ps
module isc_core import isc_pkg::*; #(
	parameter int STACK_DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic in_valid,
	input wire isc_instr_t in_instr,
	input wire logic mode_select_pin,
	input wire logic wake,
	output logic ready,
	output logic [15:0] ip,
	output logic [7:0] seg,
	output isc_flags_t flags,
	output logic [31:0] muldiv_full_reg,
	output logic [31:0] acc,
	output isc_wb_t wb,
	output isc_prefix_t prefix,
	output logic idle_mode,
	output logic power_down,
	output logic wdt_enabled,
	output logic wdt_service,
	output logic sw_reset,
	output logic sw_break,
	output logic reset_indication_out
);
	localparam int SW = $clog2(STACK_DEPTH);

	// Refuse stack depths the pointer arithmetic cannot serve
	if (STACK_DEPTH < 4 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_chk
		$error("STACK_DEPTH must be a power of two, at least 4");
	end

	isc_instr_t i;
	logic fire;
	logic [15:0] gpr [GPR_N];
	logic [15:0] stk [STACK_DEPTH];
	logic [SW-1:0] sp;
	logic [15:0] opa, opb, bin, ar, ip_adv, rel_tgt, bw, top, nxt, w0, w1;
	logic [16:0] s17;
	logic [8:0] s9;
	logic cin, is_sub, sbit, dbit, take;
	logic [31:0] prod, dvd, dvs, quo, rem, ab32, n_acc, n_md;
	logic [15:0] n_ip;
	logic [7:0] n_seg;
	isc_flags_t af, n_flags;
	isc_wb_t n_wb;
	logic [1:0] push_n, pop_n;
	logic msp_s1, msp_s2;

	// Keep only the low byte of a result for byte variants
	function automatic logic [15:0] merge(input logic b, input logic [15:0] o, input logic [15:0] r);
		merge = b ? {o[15:8], r[7:0]} : r;
	endfunction

	function automatic isc_flags_t nz_flags(input logic [15:0] r, input logic b);
		nz_flags.c = 1'b0;
		nz_flags.v = 1'b0;
		nz_flags.z = b ? (r[BYTE_MSB:0] == 8'h00) : (r == 16'h0000);
		nz_flags.n = b ? r[BYTE_MSB] : r[WORD_MSB];
	endfunction

	function automatic logic cond_met(input logic [3:0] cc, input isc_flags_t f);
		unique case (cc)
			CC_ALWAYS: cond_met = 1'b1;
			CC_Z: cond_met = f.z;
			CC_NZ: cond_met = !f.z;
			CC_C: cond_met = f.c;
			CC_NC: cond_met = !f.c;
			CC_N: cond_met = f.n;
			CC_NN: cond_met = !f.n;
			CC_V: cond_met = f.v;
			CC_NV: cond_met = !f.v;
			default: cond_met = 1'b0;
		endcase
	endfunction

	// Shifts needed to bring the leading one to the top
	function automatic logic [15:0] norm_count(input logic [15:0] v);
		norm_count = 16'h0000;
		for (int k = 0; k <= WORD_MSB; k++) begin
			if (v[k]) begin
				norm_count = 16'(WORD_MSB - k);
			end
		end
	endfunction

	// Operand fetch and shared datapath
	assign i = in_instr;
	assign fire = ce && in_valid && ready;
	assign opa = gpr[i.rd];
	assign opb = i.use_imm ? i.imm : gpr[i.rs];
	assign ab32 = {opa, opb};
	assign sbit = gpr[i.rs][i.bit_s];
	assign dbit = opa[i.bit_d];
	assign top = stk[sp - SW'(1)];
	assign nxt = stk[sp - SW'(2)];
	assign ip_adv = ip + (i.len4 ? STEP_LONG : STEP_SHORT);
	assign rel_tgt = ip_adv + {i.imm[14:0], 1'b0};
	assign is_sub = i.op inside {OP_SUB, OP_CMP, OP_CMP_DEC, OP_CMP_INC};
	assign bin = is_sub ? ~opb : opb;
	assign cin = (i.alt && i.op inside {OP_ADD, OP_SUB}) ? (flags.c ^ is_sub) : is_sub;
	assign s17 = {1'b0, opa} + {1'b0, bin} + {16'h0000, cin};
	assign s9 = {1'b0, opa[7:0]} + {1'b0, bin[7:0]} + {8'h00, cin};
	assign ar = merge(i.byte_op, opa, s17[15:0]);
	assign prod = i.alt ? {16'h0000, opa} * {16'h0000, opb}
		: 32'($signed({{16{opa[15]}}, opa}) * $signed({{16{opb[15]}}, opb}));
	assign dvs = (opb == 16'h0000) ? 32'h0000_0001 : (i.alt ? {16'h0000, opb} : {{16{opb[15]}}, opb});
	assign dvd = (i.op == OP_DIV_LONG) ? muldiv_full_reg : (i.alt ? {16'h0000, muldiv_full_reg[15:0]}
		: {{16{muldiv_full_reg[15]}}, muldiv_full_reg[15:0]});
	assign quo = i.alt ? dvd / dvs : 32'($signed(dvd) / $signed(dvs));
	assign rem = i.alt ? dvd % dvs : 32'($signed(dvd) % $signed(dvs));

	// Arithmetic flags for word and byte widths
	always_comb begin
		af = nz_flags(ar, i.byte_op);
		af.c = (i.byte_op ? s9[8] : s17[16]) ^ is_sub;
		af.v = i.byte_op ? (opa[BYTE_MSB] == bin[BYTE_MSB] && ar[BYTE_MSB] != opa[BYTE_MSB])
			: (opa[WORD_MSB] == bin[WORD_MSB] && ar[WORD_MSB] != opa[WORD_MSB]);
	end

	// Execute: next state of registers, flags, flow and stack
	always_comb begin
		n_ip = ip_adv;
		n_seg = seg;
		n_flags = flags;
		n_md = muldiv_full_reg;
		n_acc = acc;
		n_wb = '0;
		n_wb.idx = i.rd;
		push_n = 2'd0;
		pop_n = 2'd0;
		w0 = 16'h0000;
		w1 = ip_adv;
		bw = opa;
		take = cond_met(i.cc, flags);
		unique case (i.op)
			OP_ADD, OP_SUB: begin
				n_wb.en = 1'b1;
				n_wb.data = ar;
				n_flags = af;
			end
			OP_CMP: n_flags = af;
			OP_MUL: n_md = prod;
			OP_DIV, OP_DIV_LONG: begin
				n_flags.v = (opb == 16'h0000);
				if (opb != 16'h0000) begin
					n_md = {rem[15:0], quo[15:0]};
				end
			end
			OP_CPL, OP_NEG: begin
				n_wb.en = 1'b1;
				n_wb.data = merge(i.byte_op, opa, (i.op == OP_CPL) ? ~opa : 16'(-opa));
				n_flags = nz_flags(n_wb.data, i.byte_op);
			end
			OP_AND, OP_OR, OP_XOR, OP_MOV: begin
				n_wb.en = 1'b1;
				n_wb.data = merge(i.byte_op, opa, (i.op == OP_AND) ? opa & opb
					: (i.op == OP_OR) ? opa | opb : (i.op == OP_XOR) ? opa ^ opb : opb);
				n_flags = nz_flags(n_wb.data, i.byte_op);
			end
			OP_BCLR, OP_BSET, OP_BIT_COPY, OP_BAND, OP_BOR, OP_BXOR: begin
				unique case (i.op)
					OP_BCLR: bw[i.bit_d] = 1'b0;
					OP_BSET: bw[i.bit_d] = 1'b1;
					OP_BIT_COPY: bw[i.bit_d] = sbit ^ i.alt;
					OP_BAND: bw[i.bit_d] = dbit & sbit;
					OP_BOR: bw[i.bit_d] = dbit | sbit;
					default: bw[i.bit_d] = dbit ^ sbit;
				endcase
				n_wb.en = 1'b1;
				n_wb.data = bw;
			end
			OP_BIT_CMP: begin
				n_flags.z = (dbit == sbit);
				n_flags.n = dbit;
				n_flags.c = sbit;
				n_flags.v = dbit ^ sbit;
			end
			OP_FIELD: begin
				n_wb.en = 1'b1;
				n_wb.data = i.alt
					? {(opa[15:8] & ~i.imm[15:8]) | (i.imm[7:0] & i.imm[15:8]), opa[7:0]}
					: {opa[15:8], (opa[7:0] & ~i.imm[15:8]) | (i.imm[7:0] & i.imm[15:8])};
			end
			OP_CMP_DEC, OP_CMP_INC: begin
				n_flags = af;
				n_wb.en = 1'b1;
				n_wb.data = (i.op == OP_CMP_INC) ? opa + (i.alt ? STEP_TWO : STEP_ONE)
					: opa - (i.alt ? STEP_TWO : STEP_ONE);
			end
			OP_NORM: begin
				n_wb.en = 1'b1;
				n_wb.data = norm_count(gpr[i.rs]);
				n_flags = nz_flags(n_wb.data, 1'b0);
			end
			OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_ARITH_SHR: begin
				n_wb.en = 1'b1;
				unique case (i.op)
					OP_SHL: n_wb.data = opa << opb[3:0];
					OP_SHR: n_wb.data = opa >> opb[3:0];
					OP_ROL: n_wb.data = 16'(({opa, opa} << opb[3:0]) >> 16);
					OP_ROR: n_wb.data = 16'({opa, opa} >> opb[3:0]);
					default: n_wb.data = 16'($signed(opa) >>> opb[3:0]);
				endcase
				n_flags = nz_flags(n_wb.data, 1'b0);
			end
			OP_WIDEN: begin
				n_wb.en = 1'b1;
				n_wb.data = i.alt ? {8'h00, opb[7:0]} : {{8{opb[BYTE_MSB]}}, opb[7:0]};
			end
			OP_JMP_ABS: n_ip = take ? i.imm : ip_adv;
			OP_JMP_IND: n_ip = take ? opb : ip_adv;
			OP_JMP_REL: n_ip = take ? rel_tgt : ip_adv;
			OP_JMP_SEG: begin
				n_ip = i.imm;
				n_seg = i.seg;
			end
			OP_JMP_BSET, OP_JMP_BCLR: begin
				if (dbit == (i.op == OP_JMP_BSET)) begin
					n_ip = rel_tgt;
					n_wb.en = i.alt;
					bw[i.bit_d] = !dbit;
					n_wb.data = bw;
				end
			end
			OP_CALL_ABS, OP_CALL_IND, OP_CALL_REL: begin
				if (take) begin
					push_n = 2'd1;
					n_ip = (i.op == OP_CALL_ABS) ? i.imm : (i.op == OP_CALL_IND) ? opb : rel_tgt;
				end
			end
			OP_CALL_SEG, OP_PUSH_CALL: begin
				push_n = 2'd2;
				w0 = (i.op == OP_CALL_SEG) ? {8'h00, seg} : opa;
				n_ip = i.imm;
				n_seg = (i.op == OP_CALL_SEG) ? i.seg : seg;
			end
			OP_TRAP: begin
				push_n = 2'd2;
				w0 = {12'h000, flags};
				n_ip = TRAP_BASE + ({9'h000, i.imm[6:0]} << TRAP_SHIFT);
			end
			OP_PUSH: begin
				push_n = 2'd1;
				w1 = opa;
			end
			OP_POP: begin
				pop_n = 2'd1;
				n_wb.en = 1'b1;
				n_wb.data = top;
			end
			OP_CTX: begin
				push_n = 2'd1;
				w1 = opa;
				n_wb.en = 1'b1;
				n_wb.data = opb;
			end
			OP_RET: begin
				n_ip = top;
				pop_n = i.alt ? 2'd2 : 2'd1;
				n_wb.en = i.alt;
				n_wb.data = nxt;
			end
			OP_RET_SEG: begin
				n_ip = top;
				n_seg = nxt[7:0];
				pop_n = 2'd2;
			end
			OP_RET_INT: begin
				n_ip = top;
				n_flags = nxt[3:0];
				pop_n = 2'd2;
			end
			OP_SW_RESET: begin
				n_ip = RESET_IP;
				n_seg = RESET_SEG;
			end
			OP_MAC_MUL: n_acc = prod;
			OP_MAC_MAC: n_acc = acc + prod;
			OP_MAC_ADD: n_acc = acc + ab32;
			OP_MAC_SUB: n_acc = acc - ab32;
			OP_MAC_SHR: n_acc = acc >> opb[3:0];
			OP_MAC_ARITH_RIGHT_SHIFT: n_acc = 32'($signed(acc) >>> opb[3:0]);
			OP_MAC_SHL: n_acc = acc << opb[3:0];
			OP_MAC_LOAD: n_acc = ab32;
			OP_MAC_STORE, OP_MAC_MOV: begin
				n_wb.en = 1'b1;
				n_wb.data = (i.op == OP_MAC_MOV) ? opb : (i.alt ? acc[15:0] : acc[31:16]);
			end
			OP_MAC_CMP: begin
				n_flags.z = (acc == ab32);
				n_flags.n = ($signed(acc) < $signed(ab32));
			end
			OP_MAC_MAX: n_acc = ($signed(ab32) > $signed(acc)) ? ab32 : acc;
			OP_MAC_MIN: n_acc = ($signed(ab32) < $signed(acc)) ? ab32 : acc;
			OP_MAC_ABS: n_acc = acc[31] ? 32'(-acc) : acc;
			OP_MAC_RND: n_acc = (acc + RND_BIAS) & RND_MASK;
			OP_MAC_NEG: n_acc = 32'(-acc);
			OP_NOP, OP_MAC_NOP, OP_BREAK, OP_IDLE, OP_PWR_DOWN, OP_WDT_SERVICE, OP_WDT_DIS,
			OP_WDT_EN, OP_END_INIT, OP_ATOMIC, OP_EXT_REG, OP_EXT_PAGE, OP_EXT_SEG: ;
			default: ;
		endcase
	end

	// Mode-select pin synchroniser
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			msp_s1 <= 1'b0;
			msp_s2 <= 1'b0;
		end else if (ce) begin
			msp_s1 <= mode_select_pin;
			msp_s2 <= msp_s1;
		end
	end

	// Architectural state: pointer, segment, flags, muldiv, accumulator
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ip <= RESET_IP;
			seg <= RESET_SEG;
			flags <= '0;
			muldiv_full_reg <= '0;
			acc <= '0;
			wb <= '0;
		end else if (ce) begin
			wb <= fire ? n_wb : '0;
			if (fire) begin
				ip <= n_ip;
				seg <= n_seg;
				flags <= n_flags;
				muldiv_full_reg <= n_md;
				acc <= n_acc;
			end
		end
	end

	// General register file
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int k = 0; k < GPR_N; k++) begin
				gpr[k] <= '0;
			end
		end else if (ce && fire && n_wb.en) begin
			gpr[n_wb.idx] <= n_wb.data;
		end
	end

	// System stack: two words at most move per instruction
	always_ff @(posedge clk) begin
		if (fire && push_n == 2'd1) begin
			stk[sp] <= w1;
		end else if (fire && push_n == 2'd2) begin
			stk[sp] <= w0;
			stk[sp + SW'(1)] <= w1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sp <= '0;
		end else if (fire) begin
			sp <= sp + SW'(push_n) - SW'(pop_n);
		end
	end

	// Power modes, watchdog control, reset indication, one-cycle pulses
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ready <= 1'b1;
			idle_mode <= 1'b0;
			power_down <= 1'b0;
			wdt_enabled <= 1'b1;
			wdt_service <= 1'b0;
			sw_reset <= 1'b0;
			sw_break <= 1'b0;
			reset_indication_out <= 1'b1;
		end else if (ce) begin
			wdt_service <= fire && i.op == OP_WDT_SERVICE;
			sw_reset <= fire && i.op == OP_SW_RESET;
			sw_break <= fire && i.op == OP_BREAK;
			if (fire && i.op == OP_IDLE) begin
				idle_mode <= 1'b1;
				ready <= 1'b0;
			end else if (fire && i.op == OP_PWR_DOWN && !msp_s2) begin
				power_down <= 1'b1;
				ready <= 1'b0;
			end else if (idle_mode && wake) begin
				idle_mode <= 1'b0;
				ready <= 1'b1;
			end
			if (fire && i.op == OP_WDT_DIS) begin
				wdt_enabled <= 1'b0;
			end else if (fire && (i.op == OP_WDT_EN || i.op == OP_SW_RESET)) begin
				wdt_enabled <= 1'b1;
			end
			if (fire && i.op == OP_END_INIT) begin
				reset_indication_out <= 1'b0;
			end else if (fire && i.op == OP_SW_RESET) begin
				reset_indication_out <= 1'b1;
			end
		end
	end

	// Prefix sequence: counts down over the following instructions
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prefix <= '0;
		end else if (fire) begin
			if (i.op inside {OP_ATOMIC, OP_EXT_REG, OP_EXT_PAGE, OP_EXT_SEG}) begin
				prefix.kind <= (i.op == OP_ATOMIC) ? PFX_ATOMIC : (i.op == OP_EXT_REG) ? PFX_REG
					: (i.op == OP_EXT_PAGE) ? PFX_PAGE : PFX_SEG;
				prefix.with_reg <= i.alt || i.op == OP_EXT_REG;
				prefix.left <= 3'({1'b0, i.imm[1:0]} + 3'd1);
				prefix.value <= opb;
			end else if (prefix.left != 3'd0) begin
				prefix.left <= prefix.left - 3'd1;
				if (prefix.left == 3'd1) begin
					prefix.kind <= PFX_NONE;
				end
			end
		end
	end

	// Checks on the execute behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_nop_ip_only: assert property (fire && i.op == OP_NOP |=>
		ip == $past(ip_adv) && flags == $past(flags) && !wb.en) else $error("nop changed state");
	a_long_ip_step: assert property (fire && i.op == OP_ADD && i.len4 |=>
		ip == $past(ip) + STEP_LONG) else $error("four-byte step wrong");
	a_add_carry_sum: assert property (fire && i.op == OP_ADD && i.alt && !i.byte_op |=>
		wb.data == $past(16'(opa + opb + {15'h0000, flags.c}))) else $error("add with carry wrong");
	a_byte_upper_kept: assert property (fire && i.byte_op && i.op inside {OP_ADD, OP_NEG} |=>
		wb.data[15:8] == $past(opa[15:8])) else $error("byte op touched high byte");
	a_arith_right_shift_sign_fill: assert property (fire && i.op == OP_ARITH_SHR |=>
		wb.data[15] == $past(opa[15])) else $error("sign not kept on shift");
	a_mul_unsigned: assert property (fire && i.op == OP_MUL && i.alt |=>
		muldiv_full_reg == $past({16'h0000, opa} * {16'h0000, opb})) else $error("multiply wrong");
	a_power_down_op_needs_pin: assert property (fire && i.op == OP_PWR_DOWN && msp_s2 && !power_down |=>
		!power_down) else $error("power-down entered with pin high");
	a_end_of_init_op_pin_low: assert property (fire && i.op == OP_END_INIT |=>
		!reset_indication_out ##1 (!reset_indication_out || $past(sw_reset || fire))) else $error("init end lost");
	a_prefix_count: assert property (fire && i.op == OP_ATOMIC |=>
		prefix.left == $past(3'({1'b0, i.imm[1:0]} + 3'd1)) && prefix.kind == PFX_ATOMIC) else $error("prefix count wrong");
	a_neg_value: assert property (fire && i.op == OP_NEG && !i.byte_op |=>
		wb.en && wb.data == $past(16'(-opa))) else $error("negate wrong");
	c_call_taken: cover property (fire && i.op == OP_CALL_ABS && take ##1 fire && i.op == OP_RET);
	c_trap: cover property (fire && i.op == OP_TRAP);
	c_mac_chain: cover property (fire && i.op == OP_MAC_MUL ##1 fire && i.op == OP_MAC_MAC);
	c_idle_wake: cover property (idle_mode ##1 !idle_mode);
endmodule

/* sim/isc_prog_mem.sv */
// Purpose: Program store that hands decoded instructions to the core
// Assumes: Entries are indexed by instruction pointer bits 5:1
// Notes: The bench fills entries; the read is combinational from the pointer
`timescale 1ns/100ps
module isc_prog_mem import isc_pkg::*; (
	input wire logic [15:0] ip,
	output isc_instr_t instr
);
	isc_instr_t prog [0:31];
	// Presents the entry at the current pointer, so transfers fetch the target
	assign instr = prog[ip[5:1]];
endmodule

/* sim/isc_core_bench.sv */
// Purpose: Self-checking bench of the instruction set core
// Assumes: One instruction per two cycles; model tracks registers, pointer, muldiv,
// accumulator, segment and stack
// Notes: Of the flags only the add carry is modelled; divides use the unsigned variant only
`timescale 1ns/100ps
module isc_core_bench;
	import isc_pkg::*;
	logic clk, rst_b, ce, in_valid, mode_select_pin, wake;
	logic ready, idle_mode, power_down, wdt_enabled, sw_reset, reset_indication_out;
	logic [15:0] ip;
	logic [31:0] muldiv_full_reg, md_m, acc, acc_m;
	logic [7:0] seg, seg_m;
	logic wdt_service, sw_break, c_m;
	logic [15:0] stk_m [$];
	isc_instr_t in_instr;
	isc_wb_t wb;
	isc_prefix_t prefix;
	logic [15:0] gpr [0:15];
	logic [15:0] ip_m;
	int n_mismatch, samples_checked;
	isc_prog_mem mem(.ip(ip), .instr(in_instr));
	isc_core #(.STACK_DEPTH(4)) uut(.clk(clk), .rst_b(rst_b), .ce(ce), .in_valid(in_valid),
		.in_instr(in_instr), .mode_select_pin(mode_select_pin), .wake(wake), .ready(ready),
		.ip(ip), .seg(seg), .flags(), .muldiv_full_reg(muldiv_full_reg), .acc(acc), .wb(wb),
		.prefix(prefix), .idle_mode(idle_mode), .power_down(power_down),
		.wdt_enabled(wdt_enabled), .wdt_service(wdt_service), .sw_reset(sw_reset),
		.sw_break(sw_break),
		.reset_indication_out(reset_indication_out));
	// Clock of 20 ns period
	always #10 clk = ~clk;
	// Compares one value and counts the outcome
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Prints counts and verdict, then ends the run
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Builds a decoded instruction with a random length
	function automatic isc_instr_t mk(isc_op_t op, int rd, int rs,
		int imm, int ui, int bo, int alt);
		isc_instr_t m;
		m = '0;
		m.op = op;
		m.rd = 4'(rd);
		m.rs = 4'(rs);
		m.imm = 16'(imm);
		m.use_imm = 1'(ui);
		m.byte_op = 1'(bo);
		m.alt = 1'(alt);
		m.len4 = 1'($urandom_range(1));
		return m;
	endfunction
	// Runs one instruction through the core and compares with the model
	task automatic step(input isc_instr_t i);
		logic [15:0] a, b, r, nip;
		logic wr;
		a = gpr[i.rd];
		b = i.use_imm ? i.imm : gpr[i.rs];
		wr = 1'b1;
		r = 16'h0000;
		nip = ip_m + (i.len4 ? 16'h0004 : 16'h0002);
		case (i.op)
			OP_ADD: {c_m, r} = {1'b0, a} + {1'b0, b} + {16'h0000, i.alt & c_m};
			OP_SUB: r = a - b;
			OP_CPL: r = ~a;
			OP_NEG: r = -a;
			OP_MOV: r = b;
			OP_SHL: r = a << b[3:0];
			OP_ARITH_SHR: r = $signed(a) >>> b[3:0];
			OP_WIDEN: r = i.alt ? {8'h00, b[7:0]} : {{8{b[7]}}, b[7:0]};
			OP_NORM: begin
				for (int k = 0; k < 16; k++) if (b[k]) r = 16'(15 - k);
			end
			OP_MUL: begin
				wr = 1'b0;
				md_m = $signed(a) * $signed(b);
				if (i.alt) md_m = a * b;
			end
			OP_DIV: begin
				wr = 1'b0;
				md_m = {md_m[15:0] % b, md_m[15:0] / b};
			end
			OP_JMP_REL: begin
				wr = 1'b0;
				if (i.cc == CC_ALWAYS) nip = nip + {i.imm[14:0], 1'b0};
			end
			OP_SW_RESET: begin
				wr = 1'b0;
				nip = 16'h0000;
				seg_m = 8'h00;
			end
			OP_JMP_SEG: begin
				wr = 1'b0;
				nip = i.imm;
				seg_m = i.seg;
			end
			OP_FIELD: begin
				r = a;
				for (int k = 0; k < 8; k++) if (i.imm[8 + k]) r[k + 8 * i.alt] = i.imm[k];
			end
			OP_CMP_INC: r = a + (i.alt ? 16'h0002 : 16'h0001);
			OP_BIT_COPY: begin
				r = a;
				r[i.bit_d] = gpr[i.rs][i.bit_s] ^ i.alt;
			end
			OP_JMP_BSET: begin
				wr = i.alt && a[i.bit_d];
				r = a;
				r[i.bit_d] = 1'b0;
				if (a[i.bit_d]) nip = nip + {i.imm[14:0], 1'b0};
			end
			OP_CALL_ABS, OP_PUSH_CALL: begin
				wr = 1'b0;
				if (i.op == OP_PUSH_CALL) stk_m.push_back(a);
				stk_m.push_back(nip);
				nip = i.imm;
			end
			OP_TRAP: begin
				wr = 1'b0;
				stk_m.push_back(16'h0000);
				stk_m.push_back(nip);
				nip = TRAP_BASE + {7'h00, i.imm[6:0], 2'b00};
			end
			OP_RET, OP_RET_INT: begin
				wr = i.alt && i.op == OP_RET;
				nip = stk_m.pop_back();
				if (wr || i.op == OP_RET_INT) r = stk_m.pop_back();
			end
			OP_CTX: begin
				stk_m.push_back(a);
				r = b;
			end
			OP_POP: r = stk_m.pop_back();
			OP_MAC_LOAD: begin
				wr = 1'b0;
				acc_m = {a, b};
			end
			OP_MAC_ADD: begin
				wr = 1'b0;
				acc_m = acc_m + {a, b};
			end
			OP_MAC_NEG: begin
				wr = 1'b0;
				acc_m = -acc_m;
			end
			OP_MAC_STORE: r = i.alt ? acc_m[15:0] : acc_m[31:16];
			default: wr = 1'b0;
		endcase
		if (i.byte_op) r = {a[15:8], r[7:0]};
		@(posedge clk);
		mem.prog[ip_m[5:1]] <= i;
		in_valid <= 1'b1;
		@(posedge clk);
		in_valid <= 1'b0;
		#1;
		check(ip, nip);
		check(wb.en, wr);
		check(muldiv_full_reg, md_m);
		check(acc, acc_m);
		check(seg, seg_m);
		if (wr) begin
			check(wb.data, r);
			check(wb.idx, i.rd);
			gpr[i.rd] = r;
		end
		ip_m = nip;
	endtask
	// Main sequence
	initial begin
		isc_instr_t t;
		int seed;
		seed = $urandom(18174);
		clk = 0;
		rst_b = 0;
		ce = 1;
		in_valid = 0;
		mode_select_pin = 1;
		wake = 0;
		md_m = 0;
		acc_m = 0;
		seg_m = 0;
		c_m = 0;
		ip_m = 0;
		for (int k = 0; k < 16; k++) gpr[k] = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		check(reset_indication_out, 1);
		check(wdt_enabled, 1);
		for (int k = 1; k < 5; k++) step(mk(OP_MOV, 4'(k), 0, 16'($urandom), 1, 0, 0));
		for (int k = 0; k < 8; k++) step(mk(k[0] ? OP_SUB : OP_ADD, 4'(1 + k % 3),
			4'(2 + k % 2), 16'($urandom), k[1], k[2], 0));
		step(mk(OP_MUL, 1, 2, 0, 0, 0, 0));
		step(mk(OP_MUL, 3, 4, 0, 0, 0, 1));
		step(mk(OP_MOV, 5, 0, 16'($urandom_range(255, 1)), 1, 0, 0));
		step(mk(OP_DIV, 6, 5, 0, 0, 0, 1));
		step(mk(OP_CPL, 1, 0, 0, 0, 0, 0));
		step(mk(OP_NEG, 2, 0, 0, 0, 1, 0));
		step(mk(OP_CPL, 3, 0, 0, 0, 1, 0));
		step(mk(OP_SHL, 1, 0, 16'h0005, 1, 0, 0));
		step(mk(OP_ARITH_SHR, 2, 0, 16'h0003, 1, 0, 0));
		step(mk(OP_WIDEN, 7, 0, 16'h12A5, 1, 0, 0));
		step(mk(OP_WIDEN, 8, 0, 16'h12A5, 1, 0, 1));
		step(mk(OP_NORM, 9, 4, 0, 0, 0, 0));
		step(mk(OP_JMP_REL, 0, 0, 16'h0003, 0, 0, 0));
		t = mk(OP_JMP_REL, 0, 0, 16'h0003, 0, 0, 0);
		t.cc = 4'hF;
		step(t);
		step(mk(OP_MOV, 10, 0, 16'hFFFF, 1, 0, 0));
		step(mk(OP_ADD, 10, 0, 16'h0001, 1, 0, 0));
		step(mk(OP_ADD, 10, 0, 16'h0005, 1, 0, 1));
		step(mk(OP_NEG, 4, 0, 0, 0, 0, 0));
		step(mk(OP_FIELD, 11, 0, 16'h3CA5, 1, 0, 1));
		step(mk(OP_CMP_INC, 11, 0, 16'h0000, 1, 0, 1));
		t = mk(OP_BIT_COPY, 12, 10, 0, 0, 0, 1);
		t.bit_d = 4'h9;
		step(t);
		t = mk(OP_JMP_BSET, 12, 0, 16'h0004, 0, 0, 1);
		t.bit_d = 4'h9;
		step(t);
		step(mk(OP_CALL_ABS, 0, 0, 16'h0020, 0, 0, 0));
		step(mk(OP_PUSH_CALL, 10, 0, 16'h0030, 0, 0, 0));
		step(mk(OP_RET, 13, 0, 0, 0, 0, 1));
		step(mk(OP_RET, 0, 0, 0, 0, 0, 0));
		step(mk(OP_TRAP, 0, 0, 16'h0005, 0, 0, 0));
		step(mk(OP_RET_INT, 0, 0, 0, 0, 0, 0));
		step(mk(OP_CTX, 14, 0, 16'hBEEF, 1, 0, 0));
		step(mk(OP_POP, 15, 0, 0, 0, 0, 0));
		step(mk(OP_MAC_LOAD, 1, 2, 0, 0, 0, 0));
		step(mk(OP_MAC_ADD, 3, 4, 0, 0, 0, 0));
		step(mk(OP_MAC_NEG, 0, 0, 0, 0, 0, 0));
		step(mk(OP_MAC_STORE, 5, 0, 0, 0, 0, 0));
		t = mk(OP_JMP_SEG, 0, 0, 16'h0010, 0, 0, 0);
		t.seg = 8'h5A;
		step(t);
		step(mk(OP_WDT_SERVICE, 0, 0, 0, 0, 0, 0));
		check(wdt_service, 1);
		step(mk(OP_BREAK, 0, 0, 0, 0, 0, 0));
		check(sw_break, 1);
		step(mk(OP_END_INIT, 0, 0, 0, 0, 0, 0));
		check(reset_indication_out, 0);
		step(mk(OP_WDT_DIS, 0, 0, 0, 0, 0, 0));
		check(wdt_enabled, 0);
		step(mk(OP_WDT_EN, 0, 0, 0, 0, 0, 0));
		check(wdt_enabled, 1);
		step(mk(OP_ATOMIC, 0, 0, 16'h0001, 1, 0, 0));
		check(prefix.kind, PFX_ATOMIC);
		check(prefix.left, 2);
		step(mk(OP_NOP, 0, 0, 0, 0, 0, 0));
		step(mk(OP_NOP, 0, 0, 0, 0, 0, 0));
		check(prefix.kind, PFX_NONE);
		step(mk(OP_IDLE, 0, 0, 0, 0, 0, 0));
		check({idle_mode, ready}, 2'b10);
		@(posedge clk);
		mem.prog[ip_m[5:1]] <= mk(OP_ADD, 1, 0, 1, 1, 0, 0);
		in_valid <= 1'b1;
		repeat (2) @(posedge clk);
		in_valid <= 1'b0;
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		#1;
		check(ip, ip_m);
		check({idle_mode, ready}, 2'b01);
		step(mk(OP_PWR_DOWN, 0, 0, 0, 0, 0, 0));
		check(power_down, 0);
		step(mk(OP_SW_RESET, 0, 0, 0, 0, 0, 0));
		check({sw_reset, reset_indication_out}, 2'b11);
		@(posedge clk);
		mode_select_pin <= 1'b0;
		repeat (3) @(posedge clk);
		step(mk(OP_PWR_DOWN, 0, 0, 0, 0, 0, 0));
		check({power_down, ready}, 2'b10);
		give_verdict();
	end
	// Cuts a hang short well beyond the expected run time
	initial begin
		#(20 * 3000);
		n_mismatch++;
		give_verdict();
	end
endmodule
